/* verilog/rxsac_top.sv */
// receive amplifier sequencing, agc and data/clock recovery
//
// How it works
// - first amp biased on for 0.814 us
// - then first off, second on same length
// - amplifier enables never both high
// - timing from 614 kHz pulse generator
// - gain select chooses 35 dB or 5 dB
// - saturation detect selects 5 dB gain
// - agc comparator restore returns high gain
// - compound slice is AND of two slicers
// - peak slicer disabled, threshold slicer alone
// - rx data carries compound slice by default
// - enabled recovery switches rx data after start
// - recovered clock low when recovery unused
// - recovered clock low until start symbol found
// - rx data changes on clock rising edge
// - clock pulses until enable bit cleared
// - hunt for 16-bit start symbol E2E2
// - clocking begins mid first following bit
`timescale 1ns/10ps
`include "rxsac_consts.svh"
module rxsac_top
  import rxsac_pkg::*;
#(
  parameter int BIT_CYC = `RXSAC_BIT_CYC
) (
  input wire logic clk_sys,               // 100 MHz system clock
  input wire logic rst_n,                 // async power-on reset
  input wire rxsac_slice_t slice_in,      // slicer comparator results
  input wire logic saturation_detect,     // first amp saturation onset
  input wire logic gain_restore,          // agc comparator reset request
  input wire logic recovery_en,           // control_reg_zero recovery bit
  output logic first_rf_amp_en,           // first amp bias enable
  output logic second_rf_amp_en,          // second amp bias enable
  output logic gain_high,                 // 1 = 35 dB, 0 = 5 dB
  output rxsac_host_t host_out            // data and recovered clock
);
  localparam int ON_CYC = `RXSAC_ON_CYC;
  localparam int GEN_CYC = `RXSAC_GEN_CYC;
  localparam int HALF_CYC = (BIT_CYC / 2 < 1) ? 1 : BIT_CYC / 2;
  // idle rest of the generator period; zero when the two windows fill it
  localparam int IDLE_CYC = (GEN_CYC > 2 * ON_CYC) ? GEN_CYC - 2 * ON_CYC : 0;

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic rst_s1_q, rst_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end
  wire logic rst_ok = rst_q;

  // pins are async to clk_sys; first stage feeds only the second
  logic [5:0] in_s1_q, in_s2_q;
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      in_s1_q <= 6'h00;
      in_s2_q <= 6'h00;
    end else begin
      in_s1_q <= {slice_in, saturation_detect, gain_restore, recovery_en};
      in_s2_q <= in_s1_q;
    end
  end
  wire logic thr_s = in_s2_q[5];
  wire logic pk_s = in_s2_q[4];
  wire logic pk_en_s = in_s2_q[3];
  wire logic sat_s = in_s2_q[2];
  wire logic rest_s = in_s2_q[1];
  wire logic en_s = in_s2_q[0];

  // ****************************************
  // amplifier sequencing
  // ****************************************
  rxsac_seq_t seq_q;
  logic [15:0] seq_cnt_q;
  // each amp gets ON_CYC; idle is skipped when the two windows fill the period,
  // otherwise a negative idle count would wrap and stall the amps for ages
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      seq_q <= SEQ_AMP1;
      seq_cnt_q <= 16'h0000;
    end else if (seq_cnt_q == 16'(ON_CYC - 1) && seq_q != SEQ_IDLE) begin
      if (seq_q == SEQ_AMP1) begin
        seq_q <= SEQ_AMP2;
      end else if (IDLE_CYC > 0) begin
        seq_q <= SEQ_IDLE;
      end else begin
        seq_q <= SEQ_AMP1;
      end
      seq_cnt_q <= 16'h0000;
    end else if (seq_q == SEQ_IDLE && seq_cnt_q == 16'(IDLE_CYC - 1)) begin
      seq_q <= SEQ_AMP1;
      seq_cnt_q <= 16'h0000;
    end else begin
      seq_cnt_q <= seq_cnt_q + 16'h0001;
    end
  end
  // decoded from one-hot state so both can never be high
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      first_rf_amp_en <= 1'b0;
      second_rf_amp_en <= 1'b0;
    end else begin
      first_rf_amp_en <= (seq_q == SEQ_AMP1);
      second_rf_amp_en <= (seq_q == SEQ_AMP2);
    end
  end

  // ****************************************
  // agc gain state
  // ****************************************
  // saturation wins over a simultaneous restore to protect the front end
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      gain_high <= `RXSAC_GAIN_HIGH;
    end else if (sat_s) begin
      gain_high <= ~`RXSAC_GAIN_HIGH;
    end else if (rest_s) begin
      gain_high <= `RXSAC_GAIN_HIGH;
    end
  end

  // ****************************************
  // compound slicer
  // ****************************************
  logic compound;
  always_comb begin
    compound = thr_s & (pk_s | ~pk_en_s);
  end

  // ****************************************
  // start symbol hunt and clock recovery
  // ****************************************
  rxsac_rec_t rec_q;
  logic [15:0] shift_q;
  logic [15:0] bit_cnt_q;
  logic comp_d1_q;
  logic rec_bit_q, rclk_q;
  wire logic sym_hit = (shift_q == `RXSAC_START_SYMBOL);
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      rec_q <= REC_OFF;
      shift_q <= 16'h0000;
      bit_cnt_q <= 16'h0000;
      comp_d1_q <= 1'b0;
      rec_bit_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      comp_d1_q <= compound;
      case (rec_q)
        REC_OFF: begin
          rclk_q <= 1'b0;
          shift_q <= 16'h0000;
          bit_cnt_q <= 16'h0000;
          if (en_s) begin
            rec_q <= REC_HUNT;
          end
        end
        REC_HUNT: begin
          rclk_q <= 1'b0;
          if (!en_s) begin
            rec_q <= REC_OFF;
          end else if (sym_hit) begin
            rec_q <= REC_CLOCK;
            // keep counting from the mid-bit sample so the next wrap is mid first bit
            bit_cnt_q <= 16'h0001;
            rec_bit_q <= 1'b0; // no stale bit from an earlier packet
          end else if (compound != comp_d1_q) begin
            bit_cnt_q <= 16'(HALF_CYC); // realign phase on each edge
          end else if (bit_cnt_q == 16'(BIT_CYC - 1)) begin
            bit_cnt_q <= 16'h0000;
            shift_q <= {shift_q[14:0], compound};
          end else begin
            bit_cnt_q <= bit_cnt_q + 16'h0001;
          end
        end
        REC_CLOCK: begin
          if (!en_s) begin
            rec_q <= REC_OFF;
            rclk_q <= 1'b0;
          end else if (bit_cnt_q == 16'(BIT_CYC - 1)) begin
            bit_cnt_q <= 16'h0000;
          end else begin
            bit_cnt_q <= bit_cnt_q + 16'h0001;
          end
          // rise in the middle of each bit, fall half a bit later at the boundary
          if (en_s && bit_cnt_q == 16'(BIT_CYC - 1)) begin
            rclk_q <= 1'b1;
            rec_bit_q <= compound;
          end else if (en_s && bit_cnt_q == 16'(HALF_CYC - 1)) begin
            rclk_q <= 1'b0;
          end
        end
        default: begin
          rec_q <= REC_OFF;
        end
      endcase
    end
  end

  // data registered so it changes with the clock rise
  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      host_out <= '0;
    end else begin
      host_out.recovered_clock_out <= rclk_q;
      host_out.rx_bit_out <= (rec_q == REC_CLOCK && en_s) ? rec_bit_q : compound;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_amp_excl;
    @(posedge clk_sys) disable iff (!rst_ok) !(first_rf_amp_en && second_rf_amp_en);
  endproperty
  a_amp_excl: assert property (p_amp_excl) else $error("both amps enabled");

  property p_amp2_follows;
    @(posedge clk_sys) disable iff (!rst_ok)
      $fell(first_rf_amp_en) |-> second_rf_amp_en;
  endproperty
  a_amp2_follows: assert property (p_amp2_follows) else $error("amp2 not after amp1");

  property p_amp1_len;
    @(posedge clk_sys) disable iff (!rst_ok)
      $rose(first_rf_amp_en) |-> first_rf_amp_en [*8];
  endproperty
  a_amp1_len: assert property (p_amp1_len) else $error("amp1 window short");

  property p_sat_gain;
    @(posedge clk_sys) disable iff (!rst_ok) sat_s |=> !gain_high;
  endproperty
  a_sat_gain: assert property (p_sat_gain) else $error("saturation kept high gain");

  property p_restore_gain;
    @(posedge clk_sys) disable iff (!rst_ok) (rest_s && !sat_s) |=> gain_high;
  endproperty
  a_restore_gain: assert property (p_restore_gain) else $error("restore ignored");

  property p_clk_off;
    @(posedge clk_sys) disable iff (!rst_ok)
      (rec_q != REC_CLOCK) [*2] |-> !host_out.recovered_clock_out;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock while not recovering");

  property p_slice_path;
    @(posedge clk_sys) disable iff (!rst_ok)
      (rec_q != REC_CLOCK) |=> host_out.rx_bit_out == $past(compound);
  endproperty
  a_slice_path: assert property (p_slice_path) else $error("rx data not slicer");

  property p_hit_clock;
    @(posedge clk_sys) disable iff (!rst_ok)
      (rec_q == REC_HUNT && en_s && sym_hit) |=> rec_q == REC_CLOCK;
  endproperty
  a_hit_clock: assert property (p_hit_clock) else $error("start symbol missed");
endmodule : rxsac_top

/* verilog/rxsac_consts.svh */
// constants for the receive sequencing, agc and clock recovery block
`ifndef RXSAC_CONSTS_SVH
`define RXSAC_CONSTS_SVH
`define RXSAC_CLK_HZ 100000000
`define RXSAC_PULSE_GEN_HZ 614000
`define RXSAC_ON_WINDOW_PS 814000
// on-window cycles, rounded down as a longest time, never below one
`define RXSAC_ON_CYC ((`RXSAC_ON_WINDOW_PS / 10000) < 1 ? 1 : (`RXSAC_ON_WINDOW_PS / 10000))
// one full pulse generator period in system cycles
`define RXSAC_GEN_CYC (`RXSAC_CLK_HZ / `RXSAC_PULSE_GEN_HZ)
`define RXSAC_START_SYMBOL 16'hE2E2
`define RXSAC_BIT_CYC 5208
`define RXSAC_GAIN_HIGH 1'b1
`endif

/* verilog/rxsac_pkg.sv */
// types for the receive sequencing, agc and clock recovery block
package rxsac_pkg;
  typedef enum logic [2:0] {
    SEQ_AMP1 = 3'b001,
    SEQ_AMP2 = 3'b010,
    SEQ_IDLE = 3'b100
  } rxsac_seq_t;
  typedef enum logic [2:0] {
    REC_OFF = 3'b001,
    REC_HUNT = 3'b010,
    REC_CLOCK = 3'b100
  } rxsac_rec_t;
  typedef struct packed {
    logic threshold_slicer;
    logic peak_relative_slicer;
    logic peak_slicer_en;
  } rxsac_slice_t;
  typedef struct packed {
    logic rx_bit_out;
    logic recovered_clock_out;
  } rxsac_host_t;
endpackage : rxsac_pkg

/* tb/rxsac_host_model.sv */
// host side model that collects recovered bits
`timescale 1ns/10ps
module rxsac_host_model (
  input wire logic rec_clk,   // recovered clock from the block
  input wire logic rx_bit,    // receive data from the block
  input wire logic armed,     // recovery enable as the host holds it
  output logic [7:0] got_byte, // first eight bits after the symbol
  output int n_got            // falling edges seen while armed
);
  // ****************************************
  // capture
  // ****************************************
  // sample on the falling edge, where the bit is settled; dropping the enable forgets the packet
  always @(negedge rec_clk or negedge armed) begin
    if (!armed) begin
      n_got <= 0;
    end else begin
      if (n_got < 8) begin
        got_byte <= {got_byte[6:0], rx_bit};
      end
      n_got <= n_got + 1;
    end
  end
endmodule : rxsac_host_model

/* tb/tb_rxsac_top.sv */
// self-checking bench for the receive sequencing, agc and recovery block
`timescale 1ns/10ps
`include "rxsac_consts.svh"
module tb_rxsac_top;
  import rxsac_pkg::*;
  localparam int BIT_CYC = 16; // 160 ns bits keep the run short
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  rxsac_slice_t slice_in = '0;
  logic saturation_detect = 1'b0;
  logic gain_restore = 1'b0;
  logic recovery_en = 1'b0;
  logic first_rf_amp_en;
  logic second_rf_amp_en;
  logic gain_high;
  rxsac_host_t host_out;
  logic [7:0] got_byte;
  int n_got;
  int n_fail = 0;
  int samples_checked = 0;
  // ****************************************
  // harness
  // ****************************************
  rxsac_top #(.BIT_CYC(BIT_CYC)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .slice_in(slice_in),
    .saturation_detect(saturation_detect), .gain_restore(gain_restore),
    .recovery_en(recovery_en), .first_rf_amp_en(first_rf_amp_en),
    .second_rf_amp_en(second_rf_amp_en), .gain_high(gain_high), .host_out(host_out));
  rxsac_host_model u_host (.rec_clk(host_out.recovered_clock_out),
    .rx_bit(host_out.rx_bit_out), .armed(recovery_en), .got_byte(got_byte), .n_got(n_got));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // overlap of the amplifiers would make the receiver unstable
  always @(posedge clk_sys) begin
    if (first_rf_amp_en === 1'b1 && second_rf_amp_en === 1'b1) begin
      $display("mismatch amp_overlap expected 0 seen 1");
      n_fail++;
    end
  end
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic chk_bit(string name, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      $display("mismatch %s expected %b seen %b", name, e, g);
      n_fail++;
    end
  endtask : chk_bit
  task automatic chk_vec(string name, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", name, e, g);
      n_fail++;
    end
  endtask : chk_vec
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    cyc(4);
    chk_bit("gain_high", 1'b1, gain_high);
    chk_vec("host_out", 16'h0, 16'(host_out));
    chk_vec("amps", 16'h0, {14'h0, first_rf_amp_en, second_rf_amp_en});
    cyc(4);
    rst_n = 1'b1;
    cyc(6);
  endtask : t_reset
  task automatic t_seq;
    int n1;
    int n2;
    int n3;
    n1 = 0;
    n2 = 0;
    n3 = 0;
    // skip a window already under way, then wait for a fresh rise
    for (int i = 0; i < 400 && first_rf_amp_en === 1'b1; i++) cyc(1);
    for (int i = 0; i < 400 && first_rf_amp_en !== 1'b1; i++) cyc(1);
    while (first_rf_amp_en === 1'b1 && n1 < 400) begin
      cyc(1);
      n1++;
    end
    while (second_rf_amp_en === 1'b1 && n2 < 400) begin
      cyc(1);
      n2++;
    end
    chk_vec("amp1_on", 16'(`RXSAC_ON_CYC), 16'(n1));
    chk_vec("amp2_on", 16'(`RXSAC_ON_CYC), 16'(n2));
    while (first_rf_amp_en !== 1'b1 && n3 < 400) begin
      cyc(1);
      n3++;
    end
    chk_vec("amp_idle", 16'(`RXSAC_GEN_CYC - 2 * `RXSAC_ON_CYC), 16'(n3));
  endtask : t_seq
  task automatic t_agc;
    logic [2:0] tbl [4] = '{3'b100, 3'b000, 3'b011, 3'b110};
    foreach (tbl[i]) begin
      {saturation_detect, gain_restore} = tbl[i][2:1];
      cyc(5);
      chk_bit("gain_high", tbl[i][0], gain_high);
    end
    {saturation_detect, gain_restore} = 2'b01;
    cyc(5);
  endtask : t_agc
  task automatic t_slice;
    for (int i = 0; i < 8; i++) begin
      slice_in = 3'(i);
      cyc(5);
      chk_bit("rx_bit_out", i[2] & (i[1] | ~i[0]), host_out.rx_bit_out);
      chk_bit("rec_clk", 1'b0, host_out.recovered_clock_out);
    end
  endtask : t_slice
  task automatic send_bits(logic [15:0] v, int n, logic idle);
    for (int i = n - 1; i >= 0; i--) begin
      if (idle) chk_bit("rec_clk", 1'b0, host_out.recovered_clock_out);
      slice_in = '{v[i], 1'b1, 1'b1};
      cyc(BIT_CYC);
    end
  endtask : send_bits
  task automatic t_rec;
    int n0;
    recovery_en = 1'b1;
    send_bits(16'hFFFF, 4, 1'b1);
    send_bits(`RXSAC_START_SYMBOL, 16, 1'b1);
    send_bits(16'h00A5, 8, 1'b0);
    cyc(BIT_CYC);
    chk_vec("got_byte", 16'h00A5, {8'h0, got_byte});
    n0 = n_got;
    cyc(BIT_CYC * 3);
    chk_vec("pulses", 16'h0003, 16'(n_got - n0));
    recovery_en = 1'b0;
    cyc(5);
    chk_bit("rec_clk", 1'b0, host_out.recovered_clock_out);
    slice_in = '{1'b0, 1'b1, 1'b1};
    cyc(5);
    chk_bit("rx_bit_out", 1'b0, host_out.rx_bit_out);
    recovery_en = 1'b1;
    send_bits(16'h00E2, 8, 1'b1);
    recovery_en = 1'b0;
  endtask : t_rec
  initial begin
    t_reset();
    t_seq();
    t_agc();
    t_slice();
    t_rec();
    final_report();
  end
  initial begin
    #60000;
    n_fail++;
    final_report();
  end
endmodule : tb_rxsac_top
